// [dv/core_fetch_bank_addressing_props.sv]
// Purpose: Port-level checks on the fetch and data addressing front end
// Assumes: Control run bit stays set, so fetch repeats every four clocks
// Notes: Bound to every instance of the top module
`timescale 1ns/1ns
module core_fetch_bank_addressing_props import fetch_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched outputs and inputs
  input wire logic [PC_WIDTH-1:0] progAddr,
  input wire logic progRead,
  input wire dmem_req_type dmemReq,
  input wire logic [7:0] dmemRdata,
  input wire logic [7:0] execResult,
  input wire logic [7:0] operandData,
  input wire logic execStrobe,
  input wire logic flagUpdate
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_pc_even: assert property (progAddr[0] == 1'b0)
    else $error("program address is odd");
  chk_fetch_period: assert property (progRead |=> !progRead [*3] ##1 progRead)
    else $error("fetch strobe not every four clocks");
  chk_read_phase: assert property (dmemReq.rd |-> ##2 progRead)
    else $error("operand read outside second phase");
  chk_write_phase: assert property (dmemReq.wr |-> progRead && execStrobe)
    else $error("destination write outside fourth phase");
  chk_strobe_phase: assert property (execStrobe |-> progRead)
    else $error("execute strobe outside fourth phase");
  chk_flag_phase: assert property (flagUpdate |-> progRead)
    else $error("flag update outside fourth phase");
  chk_wdata_result: assert property (dmemReq.wr && flagUpdate |-> dmemReq.wdata == execResult)
    else $error("written data differs from result");
  chk_move_data: assert property (dmemReq.wr && !flagUpdate |-> dmemReq.wdata == operandData)
    else $error("moved data differs from source operand");
  chk_operand_latch: assert property (dmemReq.rd |=> operandData == $past(dmemRdata))
    else $error("operand not latched from read data");
  cover property (dmemReq.rd);
  cover property (dmemReq.wr);
  cover property (execStrobe && flagUpdate);
endmodule

bind core_fetch_bank_addressing core_fetch_bank_addressing_props i_props (
  .clock(clock), .rst(rst), .progAddr(progAddr), .progRead(progRead), .dmemReq(dmemReq),
  .dmemRdata(dmemRdata), .execResult(execResult), .operandData(operandData),
  .execStrobe(execStrobe), .flagUpdate(flagUpdate));

// [dv/core_fetch_bank_addressing_tb_top.sv]
// Purpose: Self-checking bench for the fetch and data addressing front end
// Assumes: Slave answers with hreadyout; program runs from address zero
// Notes: Operand read addresses and their spacing in clocks are compared
`timescale 1ns/1ns
module core_fetch_bank_addressing_tb_top import fetch_pkg::*;;
  logic clock = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] execResult = 0, dmemRdata, f, v;
  logic [15:0] progData;
  logic [PC_WIDTH-1:0] progAddr;
  logic progRead, hreadyout;
  logic [3:0] k;
  dmem_req_type dmemReq;
  logic [11:0] addrQ[$], expA[5];
  int tQ[$], cyc = 0, miscompares = 0, n_checks = 0;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    execResult <= 8'($urandom);
    if (!rst && dmemReq.rd === 1'b1) begin
      addrQ.push_back(dmemReq.addr);
      tQ.push_back(cyc);
    end
  end
  core_fetch_bank_addressing i_core_fetch_bank_addressing (.clock(clock), .rst(rst),
    .progAddr(progAddr), .progRead(progRead), .progData(progData), .dmemReq(dmemReq),
    .dmemRdata(dmemRdata), .execResult(execResult), .operandData(), .execStrobe(),
    .flagUpdate(), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
    .hrdata(rd));
  prog_data_model i_prog_data_model (.clock(clock), .progAddr(progAddr),
    .progRead(progRead), .progData(progData), .dmemReq(dmemReq), .dmemRdata(dmemRdata));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = rd;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    void'($urandom(92));
    k = 4'($urandom);
    f = 8'($urandom);
    // Banked, window low/high, two-word move, goto, skipped word, lone second word
    i_prog_data_model.rom[0] = {12'h010, k};
    i_prog_data_model.rom[1] = {8'h25, f};
    i_prog_data_model.rom[2] = 16'h2420;
    i_prog_data_model.rom[3] = 16'h2490;
    i_prog_data_model.rom[4] = 16'hc123;
    i_prog_data_model.rom[5] = 16'hf456;
    i_prog_data_model.rom[6] = 16'hef20;
    i_prog_data_model.rom[32] = 16'hd001;
    i_prog_data_model.rom[33] = 16'h25bb;
    i_prog_data_model.rom[34] = 16'hf0aa;
    i_prog_data_model.rom[35] = 16'h2455;
    i_prog_data_model.rom[36] = 16'hd7ff;
    expA = '{{k, f}, 12'h020, 12'hf90, 12'h123, 12'h055};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (300) @(posedge clock);
    cmp("read count", 5, addrQ.size());
    for (int i = 0; i < 5 && i < addrQ.size(); i++) begin
      cmp("data address", expA[i], addrQ[i]);
      if (i > 0) begin
        cmp("read spacing", (i == 4) ? 28 : (i == 3) ? 8 : 4, tQ[i] - tQ[i-1]);
      end
    end
    bus(1'b0, REG_BANK_SELECT, 0, r);
    cmp("bank select", {28'h0, k}, r);
    repeat (3) begin
      v = 8'($urandom) | 8'hf0;
      bus(1'b1, REG_BANK_SELECT, {24'h0, v}, r);
      bus(1'b0, REG_BANK_SELECT, 0, r);
      cmp("bank select", {28'h0, v[3:0]}, r);
    end
    bus(1'b0, REG_CONTROL, 0, r);
    cmp("control", 32'h1, r);
    bus(1'b0, 32'h0000_0010, 0, r);
    cmp("unmapped", 32'h0, r);
    conclude();
  end
endmodule

// [dv/prog_data_model.sv]
// Purpose: Program memory and banked data RAM beside the front end
// Assumes: Word index taken from byte address bits above bit zero
// Notes: Outside its strobe each memory shows the inverse of the stored value
`timescale 1ns/1ns
module prog_data_model import fetch_pkg::*; (
  // Clock
  input wire logic clock,
  // Program memory side
  input wire logic [PC_WIDTH-1:0] progAddr,
  input wire logic progRead,
  output logic [15:0] progData,
  // Data memory side
  input wire dmem_req_type dmemReq,
  output logic [7:0] dmemRdata
);
  logic [15:0] rom [0:255];
  logic [7:0] ram [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) ram[i] = i[7:0];
    for (int i = 0; i < 256; i++) rom[i] = 16'hf000;
  end
  assign progData = progRead ? rom[progAddr[8:1]] : ~rom[progAddr[8:1]];
  assign dmemRdata = dmemReq.rd ? ram[dmemReq.addr] : ~ram[dmemReq.addr];
  always @(posedge clock) begin
    if (dmemReq.wr) ram[dmemReq.addr] <= dmemReq.wdata;
  end
endmodule

// [rtl/core_fetch_bank_addressing.sv]
// Purpose: Two-stage fetch/execute front end with banked data addressing
// Assumes: Program memory answers within one phase; data RAM answers combinationally
// Notes: ALU and stack are outside; execute strobes drive them
`timescale 1ns/1ns
module core_fetch_bank_addressing import fetch_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Program memory
  output logic [PC_WIDTH-1:0] progAddr,
  output logic progRead,
  input wire logic [15:0] progData,
  // Data memory
  output dmem_req_type dmemReq,
  input wire logic [7:0] dmemRdata,
  input wire logic [7:0] execResult,
  output logic [7:0] operandData,
  output logic execStrobe,
  output logic flagUpdate,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  phase_type phase_q, phase_d;
  logic [PC_WIDTH-1:0] pc_q, pc_d;
  logic [15:0] instr_q, instr_d;
  logic [15:0] firstWord_q, firstWord_d;
  logic secondPending_q, secondPending_d;
  logic flush_q, flush_d;
  logic run_q, run_d;
  logic [3:0] bankSelect_q, bankSelect_d;
  logic [7:0] operand_q, operand_d;
  logic [DADDR_WIDTH-1:0] srcAddr_q, srcAddr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic wrPend_q, wrPend_d;
  logic [31:0] wrAddr_q, wrAddr_d;
  opclass_type opClass;
  logic [DADDR_WIDTH-1:0] bankedAddr;
  logic [DADDR_WIDTH-1:0] destAddr;
  logic implemented;
  logic lone;
  logic usesData;
  logic pairStart;

  // Banked or window operand address
  data_addr_gen addrGen (
    .operand(instr_q[7:0]),
    .useBank(instr_q[8]),
    .bankSelect(bankSelect_q),
    .dataAddr(bankedAddr)
  );

  always_comb begin
    lone = (instr_q[15:12] == SECOND_WORD_MARK) && !secondPending_q;
    if (flush_q || lone) begin
      opClass = OP_NOP;
    end else if (secondPending_q) begin
      if (firstWord_q[15:12] == 4'hc) begin
        opClass = OP_MOVE_FF;
      end else if (firstWord_q[15:8] == 8'hec || firstWord_q[15:8] == 8'hed) begin
        opClass = OP_CALL;
      end else if (firstWord_q[15:8] == 8'hef) begin
        opClass = OP_GOTO;
      end else begin
        opClass = OP_LOAD_PTR;
      end
    end else if (instr_q[15:11] == 5'h1a) begin
      opClass = OP_BRANCH;
    end else if (instr_q[15:8] == 8'h01) begin
      opClass = OP_LOAD_BANK;
    end else begin
      opClass = OP_PLAIN;
    end
    pairStart = 1'b0;
    if (flush_q || lone || secondPending_q) begin
      pairStart = 1'b0;
    end else if (instr_q[15:12] == 4'hc) begin
      pairStart = 1'b1;
    end else if (instr_q[15:9] == 7'h76) begin
      pairStart = 1'b1;
    end else if (instr_q[15:8] == 8'hee) begin
      pairStart = 1'b1;
    end else if (instr_q[15:8] == 8'hef) begin
      pairStart = 1'b1;
    end
    // First words only carry an address, so they touch no data
    usesData = 1'b0;
    if (opClass == OP_PLAIN && !pairStart) begin
      if (instr_q[15:12] != 4'h0 && instr_q[15:12] != 4'he) begin
        usesData = 1'b1;
      end
    end
    if (opClass == OP_MOVE_FF) begin
      destAddr = instr_q[11:0];
    end else begin
      // bank and offset form 12 bits
      destAddr = bankedAddr;
    end
    implemented = (destAddr <= USER_RAM_TOP) || (destAddr >= SFR_BASE);
  end

  // Pipeline and fetch
  always_comb begin
    phase_d = phase_q;
    pc_d = pc_q;
    instr_d = instr_q;
    firstWord_d = firstWord_q;
    secondPending_d = secondPending_q;
    flush_d = flush_q;
    bankSelect_d = bankSelect_q;
    operand_d = operand_q;
    srcAddr_d = srcAddr_q;
    dmemReq = '0;
    execStrobe = 1'b0;
    flagUpdate = 1'b0;
    progRead = 1'b0;
    case (phase_q)
      PH_FIRST: begin
        phase_d = PH_SECOND;
      end
      PH_SECOND: begin
        phase_d = PH_THIRD;
        if (usesData || opClass == OP_MOVE_FF) begin
          dmemReq.rd = 1'b1;
          dmemReq.addr = (opClass == OP_MOVE_FF) ? srcAddr_q : destAddr;
          operand_d = implemented || opClass == OP_MOVE_FF ? dmemRdata : 8'h00;
        end
      end
      PH_THIRD: begin
        phase_d = PH_FOURTH;
      end
      PH_FOURTH: begin
        phase_d = PH_FIRST;
        progRead = run_q;
        if (run_q) begin
          pc_d = pc_q + PC_WORD_STEP;
        end
        if (opClass != OP_NOP) begin
          execStrobe = 1'b1;
          if (usesData || opClass == OP_MOVE_FF) begin
            dmemReq.wr = implemented;
            dmemReq.addr = destAddr;
            dmemReq.wdata = (opClass == OP_MOVE_FF) ? operand_q : execResult;
            flagUpdate = usesData;
          end
          if (opClass == OP_LOAD_BANK) begin
            bankSelect_d = instr_q[3:0];
          end
        end
        instr_d = progData;
        flush_d = 1'b0;
        secondPending_d = 1'b0;
        if (pairStart) begin
          firstWord_d = instr_q;
          secondPending_d = 1'b1;
          srcAddr_d = instr_q[11:0];
        end
        if (opClass == OP_GOTO || opClass == OP_CALL) begin
          pc_d = {instr_q[11:0], firstWord_q[7:0], 1'b0};
          flush_d = 1'b1;
        end else if (opClass == OP_BRANCH) begin
          pc_d = pc_q + {{(PC_WIDTH-12){instr_q[10]}}, instr_q[10:0], 1'b0};
          flush_d = 1'b1;
        end
        if (!run_q) begin
          flush_d = 1'b1;
        end
      end
      default: begin
        phase_d = PH_FIRST;
      end
    endcase
    if (wrPend_q && wrAddr_q == REG_BANK_SELECT) begin
      bankSelect_d = hwdata[3:0];
    end
    if (wrPend_q && wrAddr_q == REG_PC) begin
      pc_d = {hwdata[PC_WIDTH-1:1], 1'b0};
      flush_d = 1'b1;
    end
  end

  // AHB-Lite slave, zero wait states
  always_comb begin
    wrPend_d = 1'b0;
    wrAddr_d = wrAddr_q;
    hrdata_d = hrdata_q;
    run_d = run_q;
    if (wrPend_q && wrAddr_q == REG_CONTROL) begin
      run_d = hwdata[0];
    end
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      wrPend_d = hwrite;
      wrAddr_d = haddr;
      if (!hwrite) begin
        if (haddr == REG_BANK_SELECT) begin
          hrdata_d = {28'h0000000, bankSelect_q};
        end else if (haddr == REG_PC) begin
          hrdata_d = {11'h000, pc_q[PC_WIDTH-1:1], 1'b0};
        end else if (haddr == REG_STATUS) begin
          hrdata_d = {instr_q, 7'h00, secondPending_q, opClass};
        end else if (haddr == REG_CONTROL) begin
          hrdata_d = {31'h00000000, run_q};
        end else begin
          hrdata_d = 32'h00000000;
        end
      end
    end
  end

  // Pipeline registers
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_q <= PH_FIRST;
      pc_q <= PC_RESET;
      instr_q <= 16'h0000;
      firstWord_q <= 16'h0000;
      secondPending_q <= 1'b0;
      flush_q <= 1'b1;
      bankSelect_q <= BANK_SELECT_RESET[3:0];
      operand_q <= 8'h00;
      srcAddr_q <= 12'h000;
    end else begin
      phase_q <= phase_d;
      pc_q <= pc_d;
      instr_q <= instr_d;
      firstWord_q <= firstWord_d;
      secondPending_q <= secondPending_d;
      flush_q <= flush_d;
      bankSelect_q <= bankSelect_d;
      operand_q <= operand_d;
      srcAddr_q <= srcAddr_d;
    end
  end

  // Bus side registers
  always_ff @(posedge clock) begin
    if (rst) begin
      run_q <= 1'b1;
      hrdata_q <= 32'h00000000;
      wrPend_q <= 1'b0;
      wrAddr_q <= 32'h00000000;
    end else begin
      run_q <= run_d;
      hrdata_q <= hrdata_d;
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
    end
  end

  assign progAddr = pc_q;
  assign operandData = operand_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
endmodule

// [rtl/data_addr_gen.sv]
// Purpose: Forms a 12-bit data address from bank select or the access bank and an 8-bit operand
// Assumes: Operand and window bit come from the executing instruction
// Notes: Addresses that fall in no implemented location are flagged by the front end, not here
`timescale 1ns/1ns
module data_addr_gen import fetch_pkg::*; (
  // Operand side
  input wire logic [7:0] operand,
  input wire logic useBank,
  input wire logic [3:0] bankSelect,
  // Address out
  output logic [DADDR_WIDTH-1:0] dataAddr
);
  always_comb begin
    if (useBank) begin
      dataAddr = {bankSelect, operand};
    end else if (operand < ACCESS_SPLIT) begin
      dataAddr = {ACCESS_LOW_BANK, operand};
    end else begin
      dataAddr = {ACCESS_HIGH_BANK, operand};
    end
  end
endmodule

// [rtl/fetch_pkg.sv]
// Purpose: Shared constants and types for the fetch and data addressing front end
// Assumes: One core clock, four phases per instruction cycle
// Notes: Register offsets are byte addresses on the AHB-Lite slave
package fetch_pkg;
  localparam int PC_WIDTH = 21;
  localparam int DADDR_WIDTH = 12;
  localparam int PHASE_COUNT = 4;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_WIDTH-1:0] PC_WORD_STEP = 21'h000002;
  localparam logic [3:0] SECOND_WORD_MARK = 4'hf;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [7:0] BANK_SELECT_RESET = 8'h00;
  localparam logic [DADDR_WIDTH-1:0] USER_RAM_TOP = 12'hedf;
  localparam logic [DADDR_WIDTH-1:0] SFR_BASE = 12'he80;
  localparam logic [31:0] REG_BANK_SELECT = 32'h0000_0000;
  localparam logic [31:0] REG_PC = 32'h0000_0004;
  localparam logic [31:0] REG_STATUS = 32'h0000_0008;
  localparam logic [31:0] REG_CONTROL = 32'h0000_000c;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [3:0] {
    PH_FIRST = 4'h1,
    PH_SECOND = 4'h2,
    PH_THIRD = 4'h4,
    PH_FOURTH = 4'h8
  } phase_type;

  // Decoded instruction classes
  typedef enum logic [7:0] {
    OP_PLAIN = 8'h01,
    OP_GOTO = 8'h02,
    OP_CALL = 8'h04,
    OP_BRANCH = 8'h08,
    OP_MOVE_FF = 8'h10,
    OP_LOAD_PTR = 8'h20,
    OP_LOAD_BANK = 8'h40,
    OP_NOP = 8'h80
  } opclass_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [DADDR_WIDTH-1:0] addr;
    logic [7:0] wdata;
  } dmem_req_type;
endpackage
